// ==== shared/tsec_defs.vh ====
// constants of the two-stage event controller: offsets, reset values, field layouts
`ifndef TSEC_DEFS_VH
`define TSEC_DEFS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TSEC_OFF_LATCH 8'h00
`define TSEC_OFF_ENABLE 8'h04
`define TSEC_OFF_ACTIVE 8'h08
`define TSEC_OFF_CTRL 8'h0c
`define TSEC_OFF_U0_ENA 8'h10
`define TSEC_OFF_U0_STAT 8'h14
`define TSEC_OFF_U0_WAKE 8'h18
`define TSEC_OFF_U0_ASGN0 8'h1c
`define TSEC_OFF_U0_ASGN1 8'h20
`define TSEC_OFF_U0_ASGN2 8'h24
`define TSEC_OFF_U0_ASGN3 8'h28
`define TSEC_OFF_U1_ENA 8'h30
`define TSEC_OFF_U1_STAT 8'h34
`define TSEC_OFF_U1_WAKE 8'h38
`define TSEC_OFF_U1_ASGN0 8'h3c
`define TSEC_OFF_U1_ASGN1 8'h40
`define TSEC_OFF_U1_ASGN2 8'h44
`define TSEC_OFF_U1_ASGN3 8'h48

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TSEC_ASGN_RST0 32'h00000000
`define TSEC_ASGN_RST1 32'h10000000
`define TSEC_ASGN_RST2 32'h22222221
`define TSEC_ASGN_RST3 32'h33333332
`define TSEC_ASGN_RST4 32'h44444433
`define TSEC_ASGN_RST5 32'h66666554
`define TSEC_ASGN_RST6 32'h00000000
`define TSEC_ASGN_RST7 32'h00000000
`define TSEC_REG_RST 32'h00000000

// ----------------------------------------------------------------
// event layout
// ----------------------------------------------------------------
`define TSEC_EVT_MASK 32'h0000ffef
`define TSEC_FORCED_ENA 7'h0f
`define TSEC_NO_EVT 5'h10
`define TSEC_SOFT_MASK 32'h0000c000
`define TSEC_GEN_LSB 7
`define TSEC_NUM_GEN 9

`endif

// ==== rtl/tsec_assign_regs.v ====
// source assignment registers of both routing units, with a registered read port
module tsec_assign_regs #(
    parameter AW = 3,
    parameter DW = 32,
    parameter NW = 8
) (
    input wire clk,
    input wire rst_n,
    input wire wr_en,
    input wire [AW-1:0] wr_idx,
    input wire [DW-1:0] wr_data,
    input wire [AW-1:0] rd_idx,
    output reg [DW-1:0] rd_data_r,
    output wire [NW*DW-1:0] all_words
);
`include "tsec_defs.vh"

    reg [DW-1:0] mem_r [0:NW-1];
    integer i;
    genvar k;

    function [DW-1:0] rst_word;
        input [AW-1:0] idx;
        begin
            case (idx)
                3'd0: rst_word = `TSEC_ASGN_RST0;
                3'd1: rst_word = `TSEC_ASGN_RST1;
                3'd2: rst_word = `TSEC_ASGN_RST2;
                3'd3: rst_word = `TSEC_ASGN_RST3;
                3'd4: rst_word = `TSEC_ASGN_RST4;
                3'd5: rst_word = `TSEC_ASGN_RST5;
                3'd6: rst_word = `TSEC_ASGN_RST6;
                default: rst_word = `TSEC_ASGN_RST7;
            endcase
        end
    endfunction

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < NW; i = i + 1) begin
                mem_r[i] <= rst_word(i[AW-1:0]);
            end
            rd_data_r <= {DW{1'b0}};
        end else begin
            if (wr_en) begin
                mem_r[wr_idx] <= wr_data;
            end
            // bypass so a read right behind a write sees the new word
            if (wr_en && wr_idx == rd_idx) begin
                rd_data_r <= wr_data;
            end else begin
                rd_data_r <= mem_r[rd_idx];
            end
        end
    end

    generate
        for (k = 0; k < NW; k = k + 1) begin : g_flat
            assign all_words[k*DW +: DW] = mem_r[k];
        end
    endgenerate

endmodule

// ==== rtl/tsec_top.v ====
// two-stage event controller: peripheral routing units, core event latch/enable/active, ahb-lite slave
//
// Function
// - each peripheral source routes to a general input by a writable assignment field
// - pll wake and all unit error sources default to general input 7
// - real-time clock and parallel port dma default to general input 8
// - eight serial port dma channels default to general input 9
// - spi dma and uart dma interrupts default to general input 10
// - timers, two-wire and can rx/tx default to general input 11
// - both gpio port interrupts default to general input 12
// - memory dma streams and watchdog default to general input 13
// - core latch, enable and active registers are 32 bits wide
// - latch sets on capture, clears on accept; supervisor clears it only while disabled
// - set enable bit lets latched event be serviced; clear bit blocks it (events 0 to 3 here stay enabled whatever the bit)
// - enable register supervisor only; global enable/disable instructions gate general inputs
// - active register holds a bit per active or nested event, read-only
// - each routing unit has 32-bit enable, status and wake-up enable registers
// - set unit enable bit passes a source on; clear bit blocks it
// - unit status bit reads one while its peripheral asserts its interrupt
// - wake-up enabled source wakes the processor if the core is idle
// - active bits act as acknowledge; simultaneous shared pulses are tolerated
// - latch sets on rising edge of a general input, detection takes two cycles
// - latch clears when active bit sets; next edge is then queued
// - least latency from input edge to active bit is three cycles
// - nine general inputs numbered 7 to 15; 14 and 15 meant for software
// - priority follows event number, 0 highest, 4 reserved
//
// Decided for this implementation: the register offsets and the AHB-Lite interface to the registers.
module tsec_top (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [3:0] hprot,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg [31:0] hrdata,
    output reg hresp,
    input wire [31:0] periph_irq0,
    input wire [31:0] periph_irq1,
    input wire [6:0] core_irq,
    input wire core_idle,
    input wire global_enable_instruction,
    input wire global_disable_instruction,
    input wire evt_accept,
    input wire evt_return,
    output reg evt_req_r,
    output reg [3:0] evt_num_r,
    output reg wake_r
);
`include "tsec_defs.vh"

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    reg [31:0] core_event_latch_r;
    reg [31:0] core_event_enable_r;
    reg [31:0] core_event_active_r;
    reg glob_en_r;
    reg [31:0] u0_ena_r;
    reg [31:0] u1_ena_r;
    reg [31:0] u0_stat_r;
    reg [31:0] u1_stat_r;
    reg [31:0] u0_wake_r;
    reg [31:0] u1_wake_r;
    reg [8:0] grp_r;
    reg [8:0] grp_d_r;
    reg [6:0] core_d1_r;
    reg [6:0] core_d2_r;
    reg wr_pend_r;
    reg wr_sup_r;
    reg [7:0] wr_addr_r;
    reg rd_wait_r;
    reg rd_sup_r;
    reg [7:0] rd_addr_r;

    reg [8:0] grp_nxt;
    reg [31:0] lat_nxt;
    reg [31:0] act_nxt;
    reg [31:0] rd_mux;
    integer g;
    integer s;

    wire [255:0] asgn_all;
    wire [31:0] asgn_rdata;
    wire addr_ph = hsel & htrans[1] & hready;
    wire wr_go = wr_pend_r & wr_sup_r;
    wire [3:0] wr_asgn = asgn_dec(wr_addr_r);
    wire [3:0] ap_asgn = asgn_dec(haddr[7:0]);
    wire [3:0] rd_asgn = asgn_dec(rd_addr_r);

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    // {hit, word index} of an assignment register address
    function [3:0] asgn_dec;
        input [7:0] a;
        begin
            case (a)
                `TSEC_OFF_U0_ASGN0: asgn_dec = 4'h8;
                `TSEC_OFF_U0_ASGN1: asgn_dec = 4'h9;
                `TSEC_OFF_U0_ASGN2: asgn_dec = 4'ha;
                `TSEC_OFF_U0_ASGN3: asgn_dec = 4'hb;
                `TSEC_OFF_U1_ASGN0: asgn_dec = 4'hc;
                `TSEC_OFF_U1_ASGN1: asgn_dec = 4'hd;
                `TSEC_OFF_U1_ASGN2: asgn_dec = 4'he;
                `TSEC_OFF_U1_ASGN3: asgn_dec = 4'hf;
                default: asgn_dec = 4'h0;
            endcase
        end
    endfunction

    // lowest set bit index, i.e. highest priority; 16 when none
    function [4:0] first_set;
        input [15:0] v;
        integer i;
        begin
            first_set = `TSEC_NO_EVT;
            for (i = 15; i >= 0; i = i - 1) begin
                if (v[i]) begin
                    first_set = i[4:0];
                end
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // assignment registers
    // ----------------------------------------------------------------
    tsec_assign_regs #(
        .AW(3),
        .DW(32),
        .NW(8)
    ) u_asgn (
        .clk(hclk),
        .rst_n(hresetn),
        .wr_en(wr_go & wr_asgn[3]),
        .wr_idx(wr_asgn[2:0]),
        .wr_data(hwdata),
        .rd_idx(ap_asgn[2:0]),
        .rd_data_r(asgn_rdata),
        .all_words(asgn_all)
    );

    // ----------------------------------------------------------------
    // routing: enable gate, assignment decode, or per general input
    // ----------------------------------------------------------------
    // a field value above 8 routes the source nowhere
    always @* begin
        grp_nxt = 9'h000;
        for (g = 0; g < `TSEC_NUM_GEN; g = g + 1) begin
            for (s = 0; s < 32; s = s + 1) begin
                if (periph_irq0[s] && u0_ena_r[s] && asgn_all[s*4 +: 4] == g[3:0]) begin
                    grp_nxt[g] = 1'b1;
                end
                if (periph_irq1[s] && u1_ena_r[s] && asgn_all[128 + s*4 +: 4] == g[3:0]) begin
                    grp_nxt[g] = 1'b1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // core event latch, active tracking and presentation
    // ----------------------------------------------------------------
    wire [15:0] edge_vec = {grp_r & ~grp_d_r, core_d1_r & ~core_d2_r};
    wire acc_go = evt_req_r & evt_accept;
    wire [31:0] acc_vec = acc_go ? ({28'h0000000, 4'h1} << evt_num_r) : 32'h00000000;
    wire [4:0] act_top = first_set(core_event_active_r[15:0]);
    wire [31:0] ret_vec = (evt_return && !act_top[4]) ? ({28'h0000000, 4'h1} << act_top[3:0]) : 32'h00000000;
    wire lat_wr = wr_go & (wr_addr_r == `TSEC_OFF_LATCH);
    wire [31:0] lat_clr = lat_wr ? (hwdata & ~core_event_enable_r) : 32'h00000000;
    wire soft_wr = wr_go & (wr_addr_r == `TSEC_OFF_CTRL);
    wire [31:0] soft_set = soft_wr ? (hwdata & `TSEC_SOFT_MASK) : 32'h00000000;
    // general inputs are gated by the global enable, events 0..3 cannot be disabled
    wire [15:0] eff_ena = {core_event_enable_r[15:7] & {9{glob_en_r}},
                           core_event_enable_r[6:0] | `TSEC_FORCED_ENA};
    wire [4:0] cand_top = first_set(lat_nxt[15:0] & eff_ena);
    wire [4:0] act_nxt_top = first_set(act_nxt[15:0]);

    always @* begin
        // new edges win over accept and software clears in the same cycle
        lat_nxt = ((core_event_latch_r & ~lat_clr & ~acc_vec)
                  | {16'h0000, edge_vec} | soft_set) & `TSEC_EVT_MASK;
        act_nxt = ((core_event_active_r & ~ret_vec) | acc_vec) & `TSEC_EVT_MASK;
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            core_event_latch_r <= `TSEC_REG_RST;
            core_event_active_r <= `TSEC_REG_RST;
            core_d1_r <= 7'h00;
            core_d2_r <= 7'h00;
            grp_r <= 9'h000;
            grp_d_r <= 9'h000;
            evt_req_r <= 1'b0;
            evt_num_r <= 4'h0;
            glob_en_r <= 1'b0;
        end else begin
            core_d1_r <= core_irq;
            core_d2_r <= core_d1_r;
            grp_r <= grp_nxt;
            grp_d_r <= grp_r;
            core_event_latch_r <= lat_nxt;
            core_event_active_r <= act_nxt;
            // request is built from next state so the edge reaches active in three cycles
            evt_req_r <= (cand_top < act_nxt_top);
            evt_num_r <= cand_top[3:0];
            if (global_disable_instruction) begin
                glob_en_r <= 1'b0;
            end else if (global_enable_instruction) begin
                glob_en_r <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // core enable and routing unit registers, status and wake-up
    // ----------------------------------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            core_event_enable_r <= `TSEC_REG_RST;
            u0_ena_r <= `TSEC_REG_RST;
            u1_ena_r <= `TSEC_REG_RST;
            u0_wake_r <= `TSEC_REG_RST;
            u1_wake_r <= `TSEC_REG_RST;
            u0_stat_r <= `TSEC_REG_RST;
            u1_stat_r <= `TSEC_REG_RST;
            wake_r <= 1'b0;
        end else begin
            u0_stat_r <= periph_irq0;
            u1_stat_r <= periph_irq1;
            wake_r <= core_idle & (|((periph_irq0 & u0_wake_r) | (periph_irq1 & u1_wake_r)));
            if (wr_go) begin
                case (wr_addr_r)
                    `TSEC_OFF_ENABLE: core_event_enable_r <= hwdata & `TSEC_EVT_MASK;
                    `TSEC_OFF_U0_ENA: u0_ena_r <= hwdata;
                    `TSEC_OFF_U0_WAKE: u0_wake_r <= hwdata;
                    `TSEC_OFF_U1_ENA: u1_ena_r <= hwdata;
                    `TSEC_OFF_U1_WAKE: u1_wake_r <= hwdata;
                    default: ;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // ahb-lite slave: writes zero-wait, reads one wait state
    // ----------------------------------------------------------------
    always @* begin
        case (rd_addr_r)
            `TSEC_OFF_LATCH: rd_mux = core_event_latch_r;
            `TSEC_OFF_ENABLE: rd_mux = core_event_enable_r;
            `TSEC_OFF_ACTIVE: rd_mux = core_event_active_r;
            `TSEC_OFF_CTRL: rd_mux = {31'h00000000, glob_en_r};
            `TSEC_OFF_U0_ENA: rd_mux = u0_ena_r;
            `TSEC_OFF_U0_STAT: rd_mux = u0_stat_r;
            `TSEC_OFF_U0_WAKE: rd_mux = u0_wake_r;
            `TSEC_OFF_U1_ENA: rd_mux = u1_ena_r;
            `TSEC_OFF_U1_STAT: rd_mux = u1_stat_r;
            `TSEC_OFF_U1_WAKE: rd_mux = u1_wake_r;
            default: rd_mux = rd_asgn[3] ? asgn_rdata : 32'h00000000;
        endcase
    end

    // user-mode accesses are answered okay but write nothing and read zero
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hrdata <= 32'h00000000;
            hresp <= 1'b0;
            wr_pend_r <= 1'b0;
            wr_sup_r <= 1'b0;
            wr_addr_r <= 8'h00;
            rd_wait_r <= 1'b0;
            rd_sup_r <= 1'b0;
            rd_addr_r <= 8'h00;
        end else begin
            hresp <= 1'b0;
            wr_pend_r <= addr_ph & hwrite;
            if (addr_ph) begin
                wr_sup_r <= hprot[1];
                wr_addr_r <= haddr[7:0];
                rd_sup_r <= hprot[1];
                rd_addr_r <= haddr[7:0];
            end
            if (addr_ph && !hwrite) begin
                hreadyout <= 1'b0;
                rd_wait_r <= 1'b1;
            end else if (rd_wait_r) begin
                hreadyout <= 1'b1;
                rd_wait_r <= 1'b0;
                hrdata <= rd_sup_r ? rd_mux : 32'h00000000;
            end
        end
    end

endmodule

// ==== bench/tsec_top_sva.sv ====
// port-level assertions for the two-stage event controller
module tsec_top_sva (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire logic [6:0] core_irq,
    input wire logic core_idle,
    input wire logic evt_accept,
    input wire logic evt_return,
    input wire logic evt_req_r,
    input wire logic [3:0] evt_num_r,
    input wire logic wake_r
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // helper state
    // ----------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire logic take = hsel && htrans[1] && hready;
    logic act0_r;
    logic [1:0] hold_r;
    // writes, accepts and returns may legally reshuffle the presented event for a while
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            act0_r <= 1'h0;
            hold_r <= 2'h0;
        end else begin
            if (evt_accept && evt_req_r && evt_num_r == 4'h0) begin
                act0_r <= 1'h1;
            end else if (evt_return) begin
                act0_r <= 1'h0;
            end
            if ((take && hwrite) || evt_accept || evt_return) begin
                hold_r <= 2'h3;
            end else if (hold_r != 2'h0) begin
                hold_r <= hold_r - 2'h1;
            end
        end
    end
    sequence rd_wait_s;
        !hreadyout ##1 hreadyout;
    endsequence
    sequence evt0_shown_s;
        ##2 (evt_req_r && evt_num_r == 4'h0);
    endsequence
    okay_resp_a: assert property (hresp == 1'h0) else $error("hresp not okay");
    read_wait_a: assert property (take && !hwrite |=> rd_wait_s) else $error("read wait wrong");
    write_nowait_a: assert property (take && hwrite |=> hreadyout) else $error("write stalled");
    rdata_hold_a: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
        else $error("hrdata moved without read");
    evt0_latency_a: assert property ($rose(core_irq[0]) && !act0_r |-> evt0_shown_s)
        else $error("event 0 late");
    no_reserved_a: assert property (evt_req_r |-> evt_num_r != 4'h4) else $error("event 4 shown");
    wake_idle_a: assert property (wake_r |-> $past(core_idle)) else $error("wake while busy");
    accept_clears_a: assert property (evt_accept && evt_req_r && !evt_return ##1 !evt_return
        |-> ##1 !(evt_req_r && evt_num_r == $past(evt_num_r, 2))) else $error("accepted event shown again");
    prio_hold_a: assert property (evt_req_r && hold_r == 2'h0 && !take && !evt_accept
        |=> !evt_req_r || evt_num_r <= $past(evt_num_r)) else $error("lower priority shown");
endmodule
bind tsec_top tsec_top_sva chk_u (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hrdata,
    .hresp, .core_irq, .core_idle, .evt_accept, .evt_return, .evt_req_r, .evt_num_r, .wake_r);

// ==== bench/tsec_core_model.sv ====
// core pipeline stand-in: accepts a presented event after a set lag, returns on command
module tsec_core_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic evt_req_r,
    input wire logic [3:0] lag,
    input wire logic ret_go,
    output logic evt_accept,
    output logic evt_return
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // accept timing
    // ----------------------------------------------------------------
    // clearing the count in the accept cycle keeps a stale request just after an accept from being taken twice, at any lag
    logic [3:0] cnt_r;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r <= 4'h0;
            evt_accept <= 1'h0;
            evt_return <= 1'h0;
        end else begin
            evt_return <= ret_go;
            evt_accept <= 1'h0;
            if (!evt_req_r || evt_accept) begin
                cnt_r <= 4'h0;
            end else if (cnt_r == lag) begin
                evt_accept <= 1'h1;
                cnt_r <= 4'h0;
            end else begin
                cnt_r <= cnt_r + 4'h1;
            end
        end
    end
endmodule

// ==== bench/tb_two_stage_event_controller.sv ====
// self-checking bench of the two-stage event controller
module tb_two_stage_event_controller;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk, hresetn, hsel, hwrite, core_idle, ret_go;
    logic rd_dph = 1'h0;
    logic global_enable_instruction, global_disable_instruction;
    logic hreadyout, hresp, evt_accept, evt_return, evt_req_r, wake_r;
    logic [31:0] haddr, hwdata, hrdata, periph_irq0, periph_irq1, word, pat;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] hprot, evt_num_r, lag;
    logic [6:0] core_irq;
    logic [7:0] rnd;
    wire logic hready = hreadyout;
    logic [31:0] rq[$];
    logic [3:0] eq[$];
    int error_cnt, samples_checked, tick;
    tsec_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hprot, .hwdata, .hready,
        .hreadyout, .hrdata, .hresp, .periph_irq0, .periph_irq1, .core_irq, .core_idle,
        .global_enable_instruction, .global_disable_instruction, .evt_accept, .evt_return,
        .evt_req_r, .evt_num_r, .wake_r);
    tsec_core_model core_u (.hclk, .hresetn, .evt_req_r, .lag, .ret_go, .evt_accept, .evt_return);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    function automatic int dg(input int u, input int s);
        if (u == 0) return s < 15 ? 7 : s < 17 ? 8 : s < 25 ? 9 : 10;
        return s < 2 ? 10 : s < 9 ? 11 : s < 11 ? 12 : s < 16 ? 13 : 7;
    endfunction
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
        samples_checked++;
        if (s !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic sup);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        hprot <= {2'h0, sup, 1'h1};
        do @(posedge hclk); while (!hready);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (!hready);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rq.push_back(e);
        bus(1'h0, a, 32'h0, 1'h1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'h1, a, d, 1'h1);
    endtask
    task automatic ret;
        ret_go <= 1'h1;
        @(posedge hclk);
        ret_go <= 1'h0;
        @(posedge hclk);
    endtask
    task automatic drain(input int n);
        while (eq.size() > n) @(posedge hclk);
        @(posedge hclk);
    endtask
    task automatic glob(input logic on);
        global_enable_instruction <= on;
        global_disable_instruction <= !on;
        @(posedge hclk);
        global_enable_instruction <= 1'h0;
        global_disable_instruction <= 1'h0;
    endtask
    task wrap_up;
        $display("checked %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // clock, monitor and timeout
    // ----------------------------------------------------------------
    initial begin
        hclk = 1'h0;
        forever #4 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        if (rd_dph && hready) cmp("hrdata", rq.pop_front(), hrdata);
        if (evt_accept && evt_req_r) cmp("evt_num_r", eq.pop_front(), {28'h0, evt_num_r});
        if (hready) rd_dph <= hsel && htrans[1] && !hwrite;
    end
    always @(posedge hclk) begin
        tick++;
        if (tick == 2000) begin
            error_cnt++;
            wrap_up();
        end
    end
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        {hresetn, hsel, hwrite, core_idle, ret_go, htrans, core_irq} = '0;
        {global_enable_instruction, global_disable_instruction, haddr, hwdata, periph_irq0, periph_irq1} = '0;
        hsize = 3'h2;
        hprot = 4'h3;
        lag = 4'h2;
        rnd = 8'h35;
        repeat (2) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        for (int u = 0; u < 2; u++) begin
            for (int w = 0; w < 4; w++) begin
                for (int i = 0; i < 8; i++) word[4*i+:4] = 4'(dg(u, 8*w+i) - 7);
                rd(8'(8'h1c + 32*u + 4*w), word);
            end
        end
        rd(8'h08, 32'h0);
        rd(8'h2c, 32'h0);
        wr(8'h04, 32'h0000ff80);
        wr(8'h10, 32'h00028000);
        wr(8'h30, 32'h00000204);
        bus(1'h1, 8'h04, 32'h0, 1'h0);
        rd(8'h04, 32'h0000ff80);
        glob(1'h1);
        rd(8'h0c, 32'h1);
        eq.push_back(4'h9);
        periph_irq0[17] <= 1'h1;
        drain(0);
        rd(8'h08, 32'h200);
        // a user-mode read of a live active register must still return zero
        rq.push_back(32'h0);
        bus(1'h0, 8'h08, 32'h0, 1'h0);
        rd(8'h00, 32'h0);
        ret();
        rd(8'h08, 32'h0);
        periph_irq0[17] <= 1'h0;
        wr(8'h24, 32'h22222201);
        eq.push_back(4'h7);
        periph_irq0[17] <= 1'h1;
        drain(0);
        ret();
        rnd = lfsr(rnd);
        pat = {rnd, ~rnd, rnd, ~rnd} & 32'hfffffdfb;
        periph_irq1 <= pat;
        core_idle <= 1'h1;
        wr(8'h38, 32'hffffffff);
        rd(8'h34, pat);
        cmp("wake_r", 32'h1, {31'h0, wake_r});
        rd(8'h00, 32'h0);
        core_idle <= 1'h0;
        periph_irq1 <= 32'h0;
        wr(8'h04, 32'h0000ef80);
        periph_irq1[9] <= 1'h1;
        repeat (2) @(posedge hclk);
        rd(8'h00, 32'h1000);
        bus(1'h1, 8'h00, 32'h1000, 1'h0);
        rd(8'h00, 32'h1000);
        wr(8'h00, 32'h1000);
        rd(8'h00, 32'h0);
        glob(1'h0);
        periph_irq0[15] <= 1'h1;
        periph_irq1[2] <= 1'h1;
        repeat (2) @(posedge hclk);
        wr(8'h00, 32'h100);
        rd(8'h00, 32'h900);
        eq.push_back(4'h8);
        eq.push_back(4'hb);
        lag <= 4'h5;
        glob(1'h1);
        drain(1);
        rd(8'h08, 32'h100);
        ret();
        drain(0);
        ret();
        eq.push_back(4'h0);
        core_irq[0] <= 1'h1;
        drain(0);
        ret();
        // software events 14 and 15 raised together: 14 first, 15 only after 14 returns
        eq.push_back(4'he);
        eq.push_back(4'hf);
        wr(8'h0c, 32'h0000c000);
        drain(1);
        rd(8'h08, 32'h4000);
        ret();
        drain(0);
        ret();
        wrap_up();
    end
endmodule
